// ---- rtl/dbt_consts.svh ----
// Constants of the dual byte bus transceiver: offsets, fields, reset values
`ifndef DBT_CONSTS_SVH
`define DBT_CONSTS_SVH

// ----------------------------------------------------------------
// Data path
// ----------------------------------------------------------------
`define DBT_WORD_W 8
`define DBT_WORDS 2

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define DBT_OFF_CTRL 12'h000
`define DBT_OFF_AB_STORE 12'h004
`define DBT_OFF_BA_STORE 12'h008
`define DBT_OFF_DRIVE_STAT 12'h00C
`define DBT_OFF_EDGE_COUNT 12'h010

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define DBT_CTRL_ISOLATE_BIT 0
`define DBT_CTRL_RESET 1'h0
`define DBT_STORE_RESET 8'h00
`define DBT_COUNT_RESET 32'h00000000
`define DBT_HSIZE_WORD 3'h2
`define DBT_HRESP_OKAY 1'h0

`endif

// ---- rtl/dbt_pkg.sv ----
// Types of the dual byte bus transceiver
package dbt_pkg;
	typedef logic [7:0] dbt_byte_t;
	typedef enum logic {
		DBT_DIR_A_TO_B,
		DBT_DIR_B_TO_A
	} dbt_dir_t;
endpackage

// ---- rtl/dbt_path.sv ----
// One direction of one byte: transparent, latched or clocked storage
`timescale 1ns/1ps
`include "dbt_consts.svh"
module dbt_path
	import dbt_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Controls
	input wire logic latch_open,
	input wire logic shared_clk_rise,
	input wire logic drive_en_n,
	input wire logic global_output_en_n,
	input wire logic soft_isolate,
	// Data
	input wire dbt_pkg::dbt_byte_t data_in,
	output dbt_pkg::dbt_byte_t data_out,
	output logic out_en
);
	logic latch_open_prev;
	logic latch_fall;
	logic load;
	dbt_byte_t next_store;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	assign latch_fall = latch_open_prev && !latch_open;
	// Open latch tracks input, close captures, clock edge loads
	assign load = latch_open || latch_fall || (!latch_open && shared_clk_rise);
	// No edge and latch closed: keep held level no inversion
	assign next_store = load ? data_in : data_out;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch_open_prev <= 1'b0;
		end else begin
			latch_open_prev <= latch_open;
		end
	end

	// Updated whatever the enables say
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_out <= `DBT_STORE_RESET;
		end else begin
			data_out <= next_store;
		end
	end

	// ----------------------------------------------------------------
	// Output enable
	// ----------------------------------------------------------------
	// Own enable, then global override
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_en <= 1'b0;
		end else begin
			out_en <= !drive_en_n && !global_output_en_n && !soft_isolate;
		end
	end
endmodule

// ---- rtl/dbt_top.sv ----
// Dual byte universal bus transceiver with an AHB-Lite status slave
// ----------------------------------------------------------------
// What this block does
// - Two independent bytes, one shared clock
// - One clock serves both directions, both bytes
// - All data paths are noninverting
// - Latch open makes A-to-B transparent
// - Latch closing captures A data
// - Latch closed: rising clock loads A data
// - Latch closed, clock static: hold level
// - B driven only while its enable low
// - B-to-A path mirrors A-to-B path
// - Enables separate per byte and direction
// - Global enable high floats every port
// ----------------------------------------------------------------
//
// The register offsets and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "dbt_consts.svh"
module dbt_top
	import dbt_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Shared controls
	input wire logic xfer_clk,
	input wire logic global_output_en_n,
	// Byte one controls
	input wire logic word1_a_to_b_latch_open,
	input wire logic word1_b_to_a_latch_open,
	input wire logic word1_a_to_b_drive_en_n,
	input wire logic word1_b_to_a_drive_en_n,
	// Byte two controls
	input wire logic word2_a_to_b_latch_open,
	input wire logic word2_b_to_a_latch_open,
	input wire logic word2_a_to_b_drive_en_n,
	input wire logic word2_b_to_a_drive_en_n,
	// Byte one A port
	input wire dbt_pkg::dbt_byte_t word1_a_in,
	output dbt_pkg::dbt_byte_t word1_a_out,
	output logic word1_a_oe,
	// Byte one B port
	input wire dbt_pkg::dbt_byte_t word1_b_in,
	output dbt_pkg::dbt_byte_t word1_b_out,
	output logic word1_b_oe,
	// Byte two A port
	input wire dbt_pkg::dbt_byte_t word2_a_in,
	output dbt_pkg::dbt_byte_t word2_a_out,
	output logic word2_a_oe,
	// Byte two B port
	input wire dbt_pkg::dbt_byte_t word2_b_in,
	output dbt_pkg::dbt_byte_t word2_b_out,
	output logic word2_b_oe
);
	import dbt_pkg::*;

	logic xfer_clk_prev;
	logic shared_clk_rise;
	logic soft_isolate;
	logic [31:0] edge_count;
	logic wr_pending;
	logic [11:0] wr_addr;
	logic addr_phase;
	logic [31:0] next_rdata;

	dbt_byte_t path_in [`DBT_WORDS][2];
	dbt_byte_t path_out [`DBT_WORDS][2];
	logic path_oe [`DBT_WORDS][2];
	logic path_latch [`DBT_WORDS][2];
	logic path_drive_n [`DBT_WORDS][2];

	// ----------------------------------------------------------------
	// Shared clock edge
	// ----------------------------------------------------------------
	// One edge detector for every byte and direction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xfer_clk_prev <= 1'b0;
		end else begin
			xfer_clk_prev <= xfer_clk;
		end
	end

	assign shared_clk_rise = xfer_clk && !xfer_clk_prev;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			edge_count <= `DBT_COUNT_RESET;
		end else if (shared_clk_rise) begin
			edge_count <= edge_count + 32'h00000001;
		end
	end

	// ----------------------------------------------------------------
	// Path routing
	// ----------------------------------------------------------------
	// A-to-B takes A data, B-to-A takes B data
	assign path_in[0][DBT_DIR_A_TO_B] = word1_a_in;
	assign path_in[0][DBT_DIR_B_TO_A] = word1_b_in;
	assign path_in[1][DBT_DIR_A_TO_B] = word2_a_in;
	assign path_in[1][DBT_DIR_B_TO_A] = word2_b_in;
	assign path_latch[0][DBT_DIR_A_TO_B] = word1_a_to_b_latch_open;
	assign path_latch[0][DBT_DIR_B_TO_A] = word1_b_to_a_latch_open;
	assign path_latch[1][DBT_DIR_A_TO_B] = word2_a_to_b_latch_open;
	assign path_latch[1][DBT_DIR_B_TO_A] = word2_b_to_a_latch_open;
	assign path_drive_n[0][DBT_DIR_A_TO_B] = word1_a_to_b_drive_en_n;
	assign path_drive_n[0][DBT_DIR_B_TO_A] = word1_b_to_a_drive_en_n;
	assign path_drive_n[1][DBT_DIR_A_TO_B] = word2_a_to_b_drive_en_n;
	assign path_drive_n[1][DBT_DIR_B_TO_A] = word2_b_to_a_drive_en_n;

	for (genvar w = 0; w < `DBT_WORDS; w++) begin : g_word
		for (genvar d = 0; d < 2; d++) begin : g_dir
			dbt_path u_path (
				.hclk(hclk),
				.hresetn(hresetn),
				.latch_open(path_latch[w][d]),
				.shared_clk_rise(shared_clk_rise),
				.drive_en_n(path_drive_n[w][d]),
				.global_output_en_n(global_output_en_n),
				.soft_isolate(soft_isolate),
				.data_in(path_in[w][d]),
				.data_out(path_out[w][d]),
				.out_en(path_oe[w][d])
			);
		end
	end

	// A-to-B store drives B, B-to-A store drives A
	assign word1_b_out = path_out[0][DBT_DIR_A_TO_B];
	assign word1_b_oe = path_oe[0][DBT_DIR_A_TO_B];
	assign word1_a_out = path_out[0][DBT_DIR_B_TO_A];
	assign word1_a_oe = path_oe[0][DBT_DIR_B_TO_A];
	assign word2_b_out = path_out[1][DBT_DIR_A_TO_B];
	assign word2_b_oe = path_oe[1][DBT_DIR_A_TO_B];
	assign word2_a_out = path_out[1][DBT_DIR_B_TO_A];
	assign word2_a_oe = path_oe[1][DBT_DIR_B_TO_A];

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	assign addr_phase = hsel && htrans[1] && hready;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= `DBT_HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp <= `DBT_HRESP_OKAY;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pending <= 1'b0;
			wr_addr <= 12'h000;
		end else begin
			wr_pending <= addr_phase && hwrite && (hsize == `DBT_HSIZE_WORD);
			wr_addr <= haddr[11:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			soft_isolate <= `DBT_CTRL_RESET;
		end else if (wr_pending && wr_addr == `DBT_OFF_CTRL) begin
			soft_isolate <= hwdata[`DBT_CTRL_ISOLATE_BIT];
		end
	end

	// Read data prepared in the address phase
	always_comb begin
		next_rdata = 32'h00000000;
		unique case (haddr[11:0])
			`DBT_OFF_CTRL: next_rdata = {31'h00000000, soft_isolate};
			`DBT_OFF_AB_STORE: next_rdata = {16'h0000, path_out[1][DBT_DIR_A_TO_B],
				path_out[0][DBT_DIR_A_TO_B]};
			`DBT_OFF_BA_STORE: next_rdata = {16'h0000, path_out[1][DBT_DIR_B_TO_A],
				path_out[0][DBT_DIR_B_TO_A]};
			// Flags a byte with both directions driving
			`DBT_OFF_DRIVE_STAT: next_rdata = {26'h0000000,
				path_oe[1][0] && path_oe[1][1], path_oe[0][0] && path_oe[0][1],
				path_oe[1][1], path_oe[1][0], path_oe[0][1], path_oe[0][0]};
			`DBT_OFF_EDGE_COUNT: next_rdata = edge_count;
			default: next_rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (addr_phase && !hwrite) begin
			hrdata <= next_rdata;
		end
	end
endmodule

// ---- verification/dbt_top_asserts.sv ----
// Port checker of the dual byte transceiver
`timescale 1ns/1ps
module dbt_top_chk
	import dbt_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Controls
	input wire logic xfer_clk,
	input wire logic global_output_en_n,
	input wire logic word1_a_to_b_latch_open,
	input wire logic word1_b_to_a_latch_open,
	input wire logic word2_a_to_b_latch_open,
	input wire logic word2_b_to_a_latch_open,
	input wire logic word1_a_to_b_drive_en_n,
	input wire logic word2_a_to_b_drive_en_n,
	input wire logic word2_b_to_a_drive_en_n,
	// Ports
	input wire dbt_pkg::dbt_byte_t word1_a_in,
	input wire dbt_pkg::dbt_byte_t word2_a_in,
	input wire dbt_pkg::dbt_byte_t word2_b_in,
	input wire dbt_pkg::dbt_byte_t word1_a_out,
	input wire dbt_pkg::dbt_byte_t word1_b_out,
	input wire dbt_pkg::dbt_byte_t word2_a_out,
	input wire dbt_pkg::dbt_byte_t word2_b_out,
	input wire logic word1_b_oe,
	input wire logic word2_a_oe,
	input wire logic word2_b_oe
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_b1_drive_gate: assert property (
		word1_b_oe |-> !$past(word1_a_to_b_drive_en_n) && !$past(global_output_en_n))
		else $error("byte one B driven while disabled");
	a_a2_drive_gate: assert property (
		word2_a_oe |-> !$past(word2_b_to_a_drive_en_n) && !$past(global_output_en_n))
		else $error("byte two A driven while disabled");
	a_b2_float: assert property (
		$past(word2_a_to_b_drive_en_n) |-> !word2_b_oe)
		else $error("byte two B not floated");
	a_global_float: assert property (
		$past(global_output_en_n) |-> !(word1_b_oe || word2_a_oe || word2_b_oe))
		else $error("port driven while globally floated");
	a_open_follow: assert property (
		$past(word1_a_to_b_latch_open) && $past(hresetn) |-> word1_b_out == $past(word1_a_in))
		else $error("transparent path lost data");
	a_close_capture: assert property (
		$past(hresetn, 2) && $past(word2_b_to_a_latch_open, 2) && !$past(word2_b_to_a_latch_open)
		|-> word2_a_out == $past(word2_b_in))
		else $error("closing capture wrong");
	a_clock_load: assert property (
		$past(hresetn, 2) && !$past(word2_a_to_b_latch_open) && $past(xfer_clk)
		&& !$past(xfer_clk, 2) |-> word2_b_out == $past(word2_a_in))
		else $error("clocked load wrong");
	a_static_hold: assert property (
		$past(hresetn, 2) && !$past(word1_b_to_a_latch_open) && !$past(word1_b_to_a_latch_open, 2)
		&& !($past(xfer_clk) && !$past(xfer_clk, 2)) |-> $stable(word1_a_out))
		else $error("stored byte changed without load");
endmodule
bind dbt_top dbt_top_chk chk_u (.hclk, .hresetn, .xfer_clk, .global_output_en_n,
	.word1_a_to_b_latch_open, .word1_b_to_a_latch_open, .word2_a_to_b_latch_open,
	.word2_b_to_a_latch_open, .word1_a_to_b_drive_en_n, .word2_a_to_b_drive_en_n,
	.word2_b_to_a_drive_en_n, .word1_a_in, .word2_a_in, .word2_b_in, .word1_a_out,
	.word1_b_out, .word2_a_out, .word2_b_out, .word1_b_oe, .word2_a_oe, .word2_b_oe);

// ---- verification/dbt_far_model.sv ----
// Card logic on A and terminated backplane on B for one byte
`timescale 1ns/1ps
module dbt_far_model
	import dbt_pkg::*;
(
	// Clock
	input wire logic hclk,
	// Card side
	input wire dbt_pkg::dbt_byte_t cd,
	input wire logic cdrv,
	input wire dbt_pkg::dbt_byte_t ao,
	input wire logic aoe,
	output dbt_pkg::dbt_byte_t ap,
	// Backplane side
	input wire dbt_pkg::dbt_byte_t bd,
	input wire logic bdrv,
	input wire dbt_pkg::dbt_byte_t bo,
	input wire logic boe,
	output dbt_pkg::dbt_byte_t bp
);
	dbt_byte_t a_last = 8'hA5;
	always_ff @(posedge hclk) begin
		a_last <= ap;
	end
	// Undriven card lines toggle
	assign ap = aoe ? ao : (cdrv ? cd : ~a_last);
	// Wired low wins, released lines pull high
	assign bp = (boe ? bo : 8'hFF) & (bdrv ? bd : 8'hFF);
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench of the dual byte transceiver
`timescale 1ns/1ps
module testbench;
	import dbt_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic xfer_clk = 1'b0, global_output_en_n = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [7:0] ctl = 8'hF0;
	dbt_byte_t cd1 = 8'h00, cd2 = 8'h00, bd1 = 8'h00, bd2 = 8'h00;
	dbt_byte_t word1_a_in, word1_a_out, word1_b_in, word1_b_out;
	dbt_byte_t word2_a_in, word2_a_out, word2_b_in, word2_b_out;
	logic word1_a_oe, word1_b_oe, word2_a_oe, word2_b_oe, hreadyout, hresp;
	logic [15:0] r, k;
	logic [72:0] q[$];
	logic [72:0] n;
	logic [35:0] got;
	int fail_count = 0;
	int cmp_count = 0;
	localparam logic [35:0] mask_dp = 36'hFFF0000FF;
	always #5 hclk = ~hclk;
	dbt_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .xfer_clk, .global_output_en_n,
		.word1_a_to_b_latch_open(ctl[0]), .word1_b_to_a_latch_open(ctl[1]),
		.word2_a_to_b_latch_open(ctl[2]), .word2_b_to_a_latch_open(ctl[3]),
		.word1_a_to_b_drive_en_n(ctl[4]), .word1_b_to_a_drive_en_n(ctl[5]),
		.word2_a_to_b_drive_en_n(ctl[6]), .word2_b_to_a_drive_en_n(ctl[7]),
		.word1_a_in, .word1_a_out, .word1_a_oe, .word1_b_in, .word1_b_out, .word1_b_oe,
		.word2_a_in, .word2_a_out, .word2_a_oe, .word2_b_in, .word2_b_out, .word2_b_oe);
	// Far side drives only where the device is disabled
	dbt_far_model far1_u (.hclk, .cd(cd1), .cdrv(ctl[5]), .ao(word1_a_out), .aoe(word1_a_oe),
		.ap(word1_a_in), .bd(bd1), .bdrv(ctl[4]), .bo(word1_b_out), .boe(word1_b_oe),
		.bp(word1_b_in));
	dbt_far_model far2_u (.hclk, .cd(cd2), .cdrv(ctl[7]), .ao(word2_a_out), .aoe(word2_a_oe),
		.ap(word2_a_in), .bd(bd2), .bdrv(ctl[6]), .bo(word2_b_out), .boe(word2_b_oe),
		.bp(word2_b_in));
	function automatic logic [35:0] ev(input logic [3:0] oe, input logic [15:0] v);
		return {oe, v[15:8], 16'h0000, v[7:0]};
	endfunction
	task automatic note(input logic s, input logic [35:0] m, input logic [35:0] v);
		q.push_back({s, m, v});
	endtask
	task automatic step(input logic [7:0] c, input logic x);
		r = 16'($urandom);
		ctl <= c;
		xfer_clk <= x;
		{bd2, cd1} <= r;
		{bd1, cd2} <= ~r;
		@(posedge hclk);
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, e);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h00000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		if (!w) note(1'b1, 36'hFFFFFFFF, {4'h0, e});
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(negedge hclk) begin
		if (q.size() > 0) begin
			n = q.pop_front();
			got = n[72] ? {4'h0, hrdata} : {word2_a_oe, word2_b_oe, word1_a_oe, word1_b_oe,
				word2_a_out, word2_b_out, word1_a_out, word1_b_out};
			cmp_count++;
			if ((got & n[71:36]) !== n[35:0]) begin
				fail_count++;
				$display("mismatch at %0t: got %h want %h", $time, got & n[71:36], n[35:0]);
			end
			if (n[72]) begin
				cmp_count++;
				if (hresp !== 1'b0) begin
					fail_count++;
					$display("mismatch at %0t: response not okay", $time);
				end
			end
		end
	end
	initial begin
		#100000;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		r = 16'($urandom(77859));
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) begin
			step(8'h69, 1'b0);
			note(1'b0, mask_dp, ev(4'h9, r));
		end
		step(8'h60, 1'b0);
		k = r;
		note(1'b0, mask_dp, ev(4'h9, k));
		step(8'h60, 1'b0);
		note(1'b0, mask_dp, ev(4'h9, k));
		step(8'h60, 1'b1);
		k = r;
		note(1'b0, mask_dp, ev(4'h9, k));
		step(8'h60, 1'b0);
		note(1'b0, mask_dp, ev(4'h9, k));
		step(8'hF0, 1'b1);
		k = r;
		note(1'b0, mask_dp, ev(4'h0, k));
		step(8'h60, 1'b0);
		note(1'b0, mask_dp, ev(4'h9, k));
		global_output_en_n <= 1'b1;
		step(8'h60, 1'b0);
		note(1'b0, mask_dp, ev(4'h0, k));
		global_output_en_n <= 1'b0;
		bus(1'b1, 12'h000, 32'h00000001, 32'h0);
		step(8'h60, 1'b0);
		note(1'b0, mask_dp, ev(4'h0, k));
		bus(1'b0, 12'h000, 32'h0, 32'h00000001);
		bus(1'b0, 12'h020, 32'h0, 32'h00000000);
		bus(1'b0, 12'h010, 32'h0, 32'h00000002);
		bus(1'b1, 12'h000, 32'h00000000, 32'h0);
		@(posedge hclk);
		bus(1'b0, 12'h00C, 32'h0, 32'h00000009);
		repeat (2) @(posedge hclk);
		tally_and_finish();
	end
endmodule
